/* core/hpio_ctrl.sv */
// external handshake partner driving a strobed 8-bit parallel port
//
// Functional notes
// - we drive input_strobe_n low to hand a byte to the device
// - we pulse acknowledge low to take the waiting byte
// - input_strobe_n stays low at least 500 ns
// - data valid by strobe rising and held 180 ns after
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "hpio_cfg.svh"
module hpio_ctrl
  import hpio_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic [`HPIO_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [31:0]             rdata,
  input  wire logic [7:0]              port_data_in,
  output logic      [7:0]              port_data_out,
  output logic      [7:0]              port_data_oe,
  output logic                         input_strobe_n,
  output logic                         ack_n,
  input  wire logic                    input_full,
  input  wire logic                    output_full_n,
  input  wire logic                    service_request
);
  localparam logic [3:0] STB_CYC  = 4'(`HPIO_STB_CYC);
  localparam logic [3:0] HOLD_CYC = 4'(`HPIO_HOLD_CYC);
  localparam logic [3:0] ACK_CYC  = 4'(`HPIO_ACK_CYC);
  localparam hpio_pins_in_t PINS_RST = '{input_full: 1'b0, output_full_n: 1'b1,
                                         service_request: 1'b0, data: 8'h00};

  hpio_pins_in_t  pins_raw;
  hpio_pins_in_t  meta_q;
  hpio_pins_in_t  sync_q;
  hpio_tx_state_t tx_q, tx_d;
  hpio_rx_state_t rx_q, rx_d;
  logic [3:0]     tx_cnt_q, tx_cnt_d;
  logic [3:0]     rx_cnt_q, rx_cnt_d;
  logic [1:0]     ctrl_q, ctrl_d;
  logic [7:0]     tx_byte_q, tx_byte_d;
  logic           tx_pend_q, tx_pend_d;
  logic [7:0]     rx_byte_q, rx_byte_d;
  logic           rx_valid_q, rx_valid_d;
  logic [31:0]    rdata_q, rdata_d;
  logic [7:0]     dout_q, dout_d;
  logic [7:0]     doe_q, doe_d;
  logic           stb_n_q, stb_n_d;
  logic           ack_n_q, ack_n_d;
  logic           tx_go;

  assign pins_raw = '{input_full: input_full, output_full_n: output_full_n,
                      service_request: service_request, data: port_data_in};

  // two-stage capture of everything the device drives
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q <= PINS_RST;
      sync_q <= PINS_RST;
    end else begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  // send path: present byte, strobe low, release, hold data
  always_comb begin
    tx_d      = tx_q;
    tx_cnt_d  = tx_cnt_q;
    stb_n_d   = stb_n_q;
    dout_d    = dout_q;
    doe_d     = doe_q;
    tx_go     = 1'b0;
    case (tx_q)
      HPIO_TX_IDLE: begin
        // wait until the previous byte was read out by the device's host
        if (tx_pend_q && ctrl_q[`HPIO_CTRL_TX_EN] && !sync_q.input_full &&
            rx_q == HPIO_RX_IDLE) begin
          tx_go    = 1'b1;
          dout_d   = tx_byte_q;
          doe_d    = 8'hff;
          stb_n_d  = 1'b0;
          tx_cnt_d = STB_CYC - 4'h1;
          tx_d     = HPIO_TX_STROBE;
        end
      end
      HPIO_TX_STROBE: begin
        if (tx_cnt_q == 4'h0) begin
          stb_n_d  = 1'b1;
          tx_cnt_d = HOLD_CYC - 4'h1;
          tx_d     = HPIO_TX_HOLD;
        end else begin
          tx_cnt_d = tx_cnt_q - 4'h1;
        end
      end
      HPIO_TX_HOLD: begin
        if (tx_cnt_q == 4'h0) begin
          doe_d = 8'h00;
          tx_d  = HPIO_TX_IDLE;
        end else begin
          tx_cnt_d = tx_cnt_q - 4'h1;
        end
      end
      default: begin
        tx_d    = HPIO_TX_IDLE;
        stb_n_d = 1'b1;
        doe_d   = 8'h00;
      end
    endcase
  end

  // receive path: pulse acknowledge, take byte, wait for output_full_n high
  always_comb begin
    rx_d     = rx_q;
    rx_cnt_d = rx_cnt_q;
    ack_n_d  = ack_n_q;
    rx_byte_d = rx_byte_q;
    case (rx_q)
      HPIO_RX_IDLE: begin
        if (ctrl_q[`HPIO_CTRL_RX_EN] && !sync_q.output_full_n && !rx_valid_q &&
            tx_q == HPIO_TX_IDLE && !tx_go) begin
          ack_n_d  = 1'b0;
          rx_cnt_d = ACK_CYC - 4'h1;
          rx_d     = HPIO_RX_ACK;
        end
      end
      HPIO_RX_ACK: begin
        if (rx_cnt_q == 4'h0) begin
          ack_n_d   = 1'b1;
          rx_byte_d = sync_q.data;
          rx_d      = HPIO_RX_WAIT;
        end else begin
          rx_cnt_d = rx_cnt_q - 4'h1;
        end
      end
      HPIO_RX_WAIT: begin
        if (sync_q.output_full_n) begin
          rx_d = HPIO_RX_IDLE;
        end
      end
      default: begin
        rx_d    = HPIO_RX_IDLE;
        ack_n_d = 1'b1;
      end
    endcase
  end

  // software registers
  always_comb begin
    ctrl_d     = ctrl_q;
    tx_byte_d  = tx_byte_q;
    tx_pend_d  = tx_pend_q;
    rx_valid_d = rx_valid_q;
    rdata_d    = 32'h0000_0000;
    if (tx_q == HPIO_TX_HOLD && tx_cnt_q == 4'h0) begin
      tx_pend_d = 1'b0;
    end
    if (wr_stb && addr == `HPIO_OFF_CTRL) begin
      ctrl_d = wdata[1:0];
    end
    if (wr_stb && addr == `HPIO_OFF_TXDATA && !tx_pend_q) begin
      tx_byte_d = wdata[7:0];
      tx_pend_d = 1'b1;
    end
    if (rd_stb) begin
      case (addr)
        `HPIO_OFF_CTRL:   rdata_d = {30'h0, ctrl_q};
        `HPIO_OFF_RXDATA: rdata_d = {24'h0, rx_byte_q};
        `HPIO_OFF_STATUS: rdata_d = {27'h0, sync_q.service_request, sync_q.output_full_n,
                                     sync_q.input_full, rx_valid_q, tx_pend_q};
        default:          rdata_d = 32'h0000_0000;
      endcase
      if (addr == `HPIO_OFF_RXDATA) begin
        rx_valid_d = 1'b0;
      end
    end
    // a new byte wins over a clearing read in the same cycle
    if (rx_q == HPIO_RX_ACK && rx_cnt_q == 4'h0) begin
      rx_valid_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_q       <= HPIO_TX_IDLE;
      rx_q       <= HPIO_RX_IDLE;
      tx_cnt_q   <= 4'h0;
      rx_cnt_q   <= 4'h0;
      ctrl_q     <= `HPIO_CTRL_RST;
      tx_byte_q  <= 8'h00;
      tx_pend_q  <= 1'b0;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      dout_q     <= 8'h00;
      doe_q      <= 8'h00;
      stb_n_q    <= 1'b1;
      ack_n_q    <= 1'b1;
    end else begin
      tx_q       <= tx_d;
      rx_q       <= rx_d;
      tx_cnt_q   <= tx_cnt_d;
      rx_cnt_q   <= rx_cnt_d;
      ctrl_q     <= ctrl_d;
      tx_byte_q  <= tx_byte_d;
      tx_pend_q  <= tx_pend_d;
      rx_byte_q  <= rx_byte_d;
      rx_valid_q <= rx_valid_d;
      rdata_q    <= rdata_d;
      dout_q     <= dout_d;
      doe_q      <= doe_d;
      stb_n_q    <= stb_n_d;
      ack_n_q    <= ack_n_d;
    end
  end

  assign rdata          = rdata_q;
  assign port_data_out  = dout_q;
  assign port_data_oe   = doe_q;
  assign input_strobe_n = stb_n_q;
  assign ack_n          = ack_n_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_STB_WIDTH: assert property ($fell(stb_n_q) |-> !stb_n_q [*5] ##1 stb_n_q)
    else $error("strobe low time not five cycles");
  AST_STB_DATA: assert property (!stb_n_q |-> doe_q == 8'hff && dout_q == tx_byte_q)
    else $error("strobe low without driven data");
  AST_DATA_HOLD: assert property ($rose(stb_n_q) |-> (doe_q == 8'hff && $stable(dout_q)) [*2]
                                  ##1 doe_q == 8'h00)
    else $error("data not held two cycles after strobe");
  AST_ACK_WIDTH: assert property ($fell(ack_n_q) |-> !ack_n_q [*3] ##1 ack_n_q)
    else $error("acknowledge low time not three cycles");
  AST_ACK_CAUSE: assert property ($fell(ack_n_q) |-> !$past(sync_q.output_full_n))
    else $error("acknowledge without synchronised output_full_n");

  COV_SEND: cover property ($fell(stb_n_q) ##[1:20] $fell(doe_q[0]));
  COV_RECV: cover property ($fell(ack_n_q) ##[1:20] rx_valid_q);
  COV_SET_CLR: cover property (rd_stb && addr == `HPIO_OFF_RXDATA &&
                               rx_q == HPIO_RX_ACK && rx_cnt_q == 4'h0);
endmodule

/* core/hpio_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef HPIO_CFG_SVH
`define HPIO_CFG_SVH
`define HPIO_ADDR_W       8
`define HPIO_OFF_CTRL     8'h00
`define HPIO_OFF_TXDATA   8'h04
`define HPIO_OFF_RXDATA   8'h08
`define HPIO_OFF_STATUS   8'h0c
`define HPIO_CTRL_TX_EN   0
`define HPIO_CTRL_RX_EN   1
`define HPIO_CTRL_RST     2'h0
`define HPIO_ST_TX_BUSY   0
`define HPIO_ST_RX_VALID  1
`define HPIO_ST_IN_FULL   2
`define HPIO_ST_OUT_FULLN 3
`define HPIO_ST_SRQ       4
`define HPIO_CLK_NS       100
`define HPIO_STB_MIN_NS   500
`define HPIO_HOLD_MIN_NS  180
`define HPIO_ACK_MIN_NS   300
`define HPIO_STB_CYC  ((`HPIO_STB_MIN_NS + `HPIO_CLK_NS - 1) / `HPIO_CLK_NS)
`define HPIO_HOLD_CYC ((`HPIO_HOLD_MIN_NS + `HPIO_CLK_NS - 1) / `HPIO_CLK_NS)
`define HPIO_ACK_CYC  ((`HPIO_ACK_MIN_NS + `HPIO_CLK_NS - 1) / `HPIO_CLK_NS)
`endif

/* core/hpio_pkg.sv */
// types of the handshake port controller
package hpio_pkg;
  typedef enum logic [2:0] {
    HPIO_TX_IDLE   = 3'h1,
    HPIO_TX_STROBE = 3'h2,
    HPIO_TX_HOLD   = 3'h4
  } hpio_tx_state_t;
  typedef enum logic [2:0] {
    HPIO_RX_IDLE = 3'h1,
    HPIO_RX_ACK  = 3'h2,
    HPIO_RX_WAIT = 3'h4
  } hpio_rx_state_t;
  typedef struct packed {
    logic       input_full;
    logic       output_full_n;
    logic       service_request;
    logic [7:0] data;
  } hpio_pins_in_t;
endpackage

/* tb/hpio_dev_model.sv */
// behavioural model of the strobed parallel port device
`timescale 1ns/1ns
module hpio_dev_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       input_strobe_n,
  input  wire logic       ack_n,
  input  wire logic [7:0] pins,
  input  wire logic       svc_en,
  input  wire logic       host_rd,
  input  wire logic       tx_req,
  input  wire logic [7:0] tx_byte,
  output logic            input_full,
  output logic            output_full_n,
  output logic            service_request,
  output logic      [7:0] dev_data,
  output logic      [7:0] latch_q
);
  logic stb_q;
  logic ack_q;
  logic rd_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stb_q <= 1'b1;
      ack_q <= 1'b1;
      rd_q <= 1'b0;
      input_full <= 1'b0;
      output_full_n <= 1'b1;
      service_request <= 1'b0;
      latch_q <= 8'h00;
      dev_data <= 8'h00;
    end else begin
      stb_q <= input_strobe_n;
      ack_q <= ack_n;
      rd_q <= host_rd;
      if (!input_strobe_n) begin
        latch_q <= pins;
        input_full <= 1'b1;
      end
      if (input_strobe_n && !stb_q && svc_en) service_request <= 1'b1;
      if (host_rd) service_request <= 1'b0;
      if (rd_q && !host_rd) input_full <= 1'b0;
      if (tx_req) begin
        output_full_n <= 1'b0;
        dev_data <= tx_byte;
      end else if (!ack_n) output_full_n <= 1'b1;
      // released lines keep changing
      else if (output_full_n && ack_q) dev_data <= ~dev_data;
    end
  end
endmodule

/* tb/tb_hpio_ctrl.sv */
// self-checking bench of the handshake port controller
`timescale 1ns/1ns
`include "hpio_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_hpio_ctrl;
  logic ref_clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, svc_en = 1'b1;
  logic host_rd = 1'b0, tx_req = 1'b0, stb_n, ack_n, in_full, obf_n, srq;
  logic [7:0] addr = 8'h00, tx_byte = 8'h00, pdo, poe, dev_data, latch_q, pins, hold_b, b1, b2;
  logic [31:0] wdata = 32'h0, rdata;
  integer seed = 32'h0660bf0d, fails = 0, total_checks = 0, stb_lo = 0, ack_lo = 0;
  integer acks = 0, hold_t = 0;
  always #50 ref_clk = ~ref_clk;
  assign pins = (poe == 8'hff) ? pdo : dev_data;
  hpio_ctrl i_hpio_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .port_data_in(pins),
    .port_data_out(pdo), .port_data_oe(poe), .input_strobe_n(stb_n), .ack_n(ack_n),
    .input_full(in_full), .output_full_n(obf_n), .service_request(srq));
  hpio_dev_model i_hpio_dev_model (.ref_clk(ref_clk), .rst_b(rst_b), .input_strobe_n(stb_n),
    .ack_n(ack_n), .pins(pins), .svc_en(svc_en), .host_rd(host_rd), .tx_req(tx_req),
    .tx_byte(tx_byte), .input_full(in_full), .output_full_n(obf_n), .service_request(srq),
    .dev_data(dev_data), .latch_q(latch_q));
  function automatic logic [31:0] st(input logic b, v, f, o, s);
    st = {27'h0, s, o, f, v, b};
  endfunction
  // pulse widths and data hold on the wire
  always @(posedge ref_clk) begin
    stb_lo <= stb_n ? 0 : stb_lo + 1;
    ack_lo <= ack_n ? 0 : ack_lo + 1;
    if (hold_t == 1) `CHK(pins, hold_b)
    if (rst_b && stb_n && stb_lo > 0) begin
      `CHK(stb_lo >= 5, 1'b1)
      hold_b <= pins;
      hold_t <= 1;
    end else if (hold_t > 0) hold_t <= hold_t - 1;
    if (rst_b && ack_n && ack_lo > 0) begin
      `CHK(ack_lo >= 3, 1'b1)
      acks <= acks + 1;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task pulse_rd;
    @(posedge ref_clk);
    host_rd <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
  endtask
  task present(input logic [7:0] b);
    @(posedge ref_clk);
    tx_req <= 1'b1;
    tx_byte <= b;
    @(posedge ref_clk);
    tx_req <= 1'b0;
  endtask
  task complete_run;
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(10);
    rst_b <= 1'b1;
    #1 `CHK({stb_n, ack_n, poe}, 10'h300)
    rd(`HPIO_OFF_CTRL, 32'h0);
    rd(8'h10, 32'h0);
    b1 = $random(seed);
    wr(`HPIO_OFF_TXDATA, {24'h0, b1});
    cyc(20);
    `CHK(stb_n, 1'b1)
    rd(`HPIO_OFF_STATUS, st(1, 0, 0, 1, 0));
    wr(`HPIO_OFF_CTRL, 32'h1);
    cyc(12);
    `CHK(latch_q, b1)
    rd(`HPIO_OFF_STATUS, st(0, 0, 1, 1, 1));
    pulse_rd;
    cyc(4);
    rd(`HPIO_OFF_STATUS, st(0, 0, 0, 1, 0));
    for (int i = 0; i < 3; i++) begin
      svc_en <= i[0];
      b1 = $random(seed);
      b2 = $random(seed);
      wr(`HPIO_OFF_TXDATA, {24'h0, b1});
      wr(`HPIO_OFF_TXDATA, {24'h0, ~b1});
      cyc(12);
      `CHK(latch_q, b1)
      wr(`HPIO_OFF_TXDATA, {24'h0, b2});
      cyc(12);
      `CHK(latch_q, b1)
      rd(`HPIO_OFF_STATUS, st(1, 0, 1, 1, i[0]));
      pulse_rd;
      cyc(14);
      `CHK(latch_q, b2)
      pulse_rd;
      cyc(5);
    end
    wr(`HPIO_OFF_CTRL, 32'h2);
    for (int i = 0; i < 2; i++) begin
      b1 = $random(seed);
      b2 = $random(seed);
      present(b1);
      cyc(10);
      rd(`HPIO_OFF_STATUS, st(0, 1, 0, 1, 0));
      present(b2);
      cyc(10);
      rd(`HPIO_OFF_STATUS, st(0, 1, 0, 0, 0));
      `CHK(acks, 2 * i + 1)
      rd(`HPIO_OFF_RXDATA, {24'h0, b1});
      cyc(10);
      rd(`HPIO_OFF_RXDATA, {24'h0, b2});
    end
    // both directions enabled: receive waits for the send to finish
    wr(`HPIO_OFF_CTRL, 32'h3);
    b1 = $random(seed);
    b2 = $random(seed);
    wr(`HPIO_OFF_TXDATA, {24'h0, b1});
    present(b2);
    cyc(20);
    `CHK(latch_q, b1)
    rd(`HPIO_OFF_RXDATA, {24'h0, b2});
    complete_run;
  end
  initial begin
    cyc(3000);
    fails++;
    complete_run;
  end
endmodule
